//--- rtl/apr_pkg.sv
package apr_pkg;

  // ----------------------------------------------------------------------
  // Sizes and axis lanes
  // ----------------------------------------------------------------------
  localparam int unsigned APR_ENC_BITS = 12;
  localparam int unsigned APR_POS_BITS = 32;
  localparam int unsigned APR_NUM_AXES = 2;
  localparam int unsigned APR_AXIS_MOTOR  = 0;
  localparam int unsigned APR_AXIS_MASTER = 1;

  // ----------------------------------------------------------------------
  // Multi-turn counts
  // ----------------------------------------------------------------------
  // Full count is two to the power of the multi-turn width
  localparam logic signed [31:0] APR_ENC_FULL = 32'sh0000_1000;
  localparam logic [11:0]        APR_ENC_HALF = 12'h800;
  localparam logic [19:0]        APR_ENC_PAD  = 20'h0_0000;

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  typedef enum logic {APR_IDLE, APR_CALC} apr_state_t;

  typedef struct packed {
    apr_state_t                    state;
    logic [1:0]                    homed;
    logic [1:0][11:0]              home_enc;
    logic [1:0][31:0]              home_pos;
    logic [1:0][31:0]              restored;
    logic [1:0]                    load;
    logic [1:0]                    valid;
  } apr_regs_t;

  // Power-up leaves a restore pending so it runs right after reset
  localparam apr_regs_t APR_REGS_RST = '{state: APR_CALC, default: '0};

endpackage

//--- rtl/apr_restore.sv
// How it works
// - Auto calculation off: load raw encoder reading, ignore stored home.
// - Auto calculation on and homed: compute machine position from home pair.
// - Restore runs after power-up reset release and after every warm start seen while idle.
// - Set-home records machine position and encoder reading together as pair.
// - One-sided, reading above home: reading minus home plus home position.
// - One-sided, reading below home: full count minus home plus reading plus home position.
// - One-sided is valid only within one full count of positive travel.
// - Motor and master axes keep separate settings; non-absolute disabled.
// - Two-sided splits count around home using a computed rollover point.
module apr_restore
(
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  input  wire logic                                  warm_start,
  input  wire logic [1:0]                            axis_is_absolute,
  input  wire logic [1:0]                            auto_calc_en,
  input  wire logic [1:0]                            two_sided_mode,
  input  wire logic [1:0]                            set_home_command,
  input  wire logic [1:0]                            clear_home_command,
  input  wire logic [1:0][apr_pkg::APR_ENC_BITS-1:0] encoder_reading,
  input  wire logic [1:0][apr_pkg::APR_POS_BITS-1:0] machine_position,
  output logic      [1:0][apr_pkg::APR_POS_BITS-1:0] restored_position,
  output logic      [1:0]                            position_load,
  output logic      [1:0]                            position_valid,
  output logic      [1:0]                            home_defined
);
  import apr_pkg::*;

  // ----------------------------------------------------------------------
  // Restore arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [31:0] restore_calc
  (
    input logic [11:0] pa,
    input logic [11:0] home_encoder_reading,
    input logic [31:0] home_machine_position,
    input logic        two
  );
    logic signed [31:0] d;
    logic        [11:0] roll;
    d    = $signed({APR_ENC_PAD, pa}) - $signed({APR_ENC_PAD, home_encoder_reading})
         + $signed(home_machine_position);
    // Encoder difference is shifted by one full count where the counter has wrapped
    roll = home_encoder_reading + APR_ENC_HALF;
    if (!two)
    begin
      if (pa >= home_encoder_reading)
        restore_calc = d;
      else
        restore_calc = d + APR_ENC_FULL;
    end
    else if (roll >= APR_ENC_HALF)
      restore_calc = (pa < roll) ? d : d - APR_ENC_FULL;
    else
      restore_calc = (pa < roll) ? d + APR_ENC_FULL : d;
  endfunction

  function automatic logic [31:0] raw_pos(input logic [11:0] pa);
    raw_pos = {APR_ENC_PAD, pa};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  apr_regs_t s_reg;
  apr_regs_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.load = '0;
    case (s_reg.state)
      APR_IDLE:
      begin
        if (warm_start)
          s_next.state = APR_CALC;
      end
      APR_CALC:
      begin
        s_next.state = APR_IDLE;
        for (int i = 0; i < 2; i++)
        begin
          if (axis_is_absolute[i])
          begin
            s_next.load[i] = 1'b1;
            if (auto_calc_en[i] && s_reg.homed[i])
            begin
              s_next.restored[i] = restore_calc(encoder_reading[i],
                s_reg.home_enc[i], s_reg.home_pos[i],
                two_sided_mode[i]);
              s_next.valid[i]    = 1'b1;
            end
            else
            begin
              // Stored home ignored; no valid claim without a pair
              s_next.restored[i] = raw_pos(encoder_reading[i]);
              s_next.valid[i]    = 1'b0;
            end
          end
        end
      end
      default: s_next.state = APR_IDLE;
    endcase
    for (int i = 0; i < 2; i++)
    begin
      if (clear_home_command[i])
      begin
        s_next.homed[i] = 1'b0;
        s_next.valid[i] = 1'b0;
      end
      // Set beats clear in the same cycle
      if (set_home_command[i] && axis_is_absolute[i])
      begin
        s_next.home_enc[i] = encoder_reading[i];
        s_next.home_pos[i] = machine_position[i];
        s_next.homed[i]    = 1'b1;
        s_next.valid[i]    = 1'b1;
      end
      if (!axis_is_absolute[i])
      begin
        s_next.homed[i] = 1'b0;
        s_next.valid[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_reg <= APR_REGS_RST;
    else
      s_reg <= s_next;
  end

  assign restored_position = s_reg.restored;
  assign position_load     = s_reg.load;
  assign position_valid    = s_reg.valid;
  assign home_defined      = s_reg.homed;

  // ----------------------------------------------------------------------
  // Checks on the motor lane, and one cover on the master lane
  // ----------------------------------------------------------------------
  logic        calc0;
  logic [31:0] exp_fwd0;
  logic [31:0] exp_wrap0;
  assign calc0 = (s_reg.state == APR_CALC) && axis_is_absolute[0]
              && !set_home_command[0] && !clear_home_command[0];
  assign exp_fwd0  = {APR_ENC_PAD, encoder_reading[0]}
                   - {APR_ENC_PAD, s_reg.home_enc[0]} + s_reg.home_pos[0];
  assign exp_wrap0 = exp_fwd0 + APR_ENC_FULL;

  a_powerup_restore: assert property (@(posedge core_clk)
    $fell(rst) && axis_is_absolute[0] |=> position_load[0])
    else $error("no restore after power-up");

  a_warm_restore: assert property (
    @(posedge core_clk) disable iff (rst)
    warm_start && s_reg.state == APR_IDLE && axis_is_absolute[0]
    |=> ##1 position_load[0] ##1 !position_load[0])
    else $error("warm start restore missing or too long");

  a_raw_load: assert property (
    @(posedge core_clk) disable iff (rst)
    calc0 && !auto_calc_en[0] |=>
    restored_position[0] == raw_pos($past(encoder_reading[0])))
    else $error("raw load wrong");

  a_home_capture: assert property (
    @(posedge core_clk) disable iff (rst)
    set_home_command[0] && axis_is_absolute[0] |=>
    home_defined[0] && s_reg.home_enc[0] == $past(encoder_reading[0])
    && s_reg.home_pos[0] == $past(machine_position[0]))
    else $error("home pair not captured");

  a_one_sided_fwd: assert property (
    @(posedge core_clk) disable iff (rst)
    calc0 && auto_calc_en[0] && s_reg.homed[0] && !two_sided_mode[0]
    && encoder_reading[0] >= s_reg.home_enc[0] |=>
    restored_position[0] == $past(exp_fwd0) && position_valid[0])
    else $error("one-sided forward formula wrong");

  a_one_sided_wrap: assert property (
    @(posedge core_clk) disable iff (rst)
    calc0 && auto_calc_en[0] && s_reg.homed[0] && !two_sided_mode[0]
    && encoder_reading[0] < s_reg.home_enc[0] |=>
    restored_position[0] == $past(exp_wrap0))
    else $error("one-sided wrap formula wrong");

  a_no_home_fall: assert property (
    @(posedge core_clk) disable iff (rst)
    calc0 && auto_calc_en[0] && !s_reg.homed[0] |=>
    !position_valid[0]
    && restored_position[0] == raw_pos($past(encoder_reading[0])))
    else $error("unhomed fallback wrong");

  a_non_abs_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    !$past(axis_is_absolute[0]) |-> !position_load[0]
    && !position_valid[0])
    else $error("non-absolute axis active");

  a_two_sided_eq: assert property (
    @(posedge core_clk) disable iff (rst)
    calc0 && auto_calc_en[0] && s_reg.homed[0] && two_sided_mode[0]
    && encoder_reading[0] == s_reg.home_enc[0] |=>
    restored_position[0] == $past(s_reg.home_pos[0]))
    else $error("two-sided home reading wrong");

  // A clear racing a set must not lose a freshly taken home pair
  a_set_over_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    set_home_command[0] && clear_home_command[0] && axis_is_absolute[0]
    |=> home_defined[0] && position_valid[0])
    else $error("clear beat set on home pair");

  a_load_single: assert property (
    @(posedge core_clk) disable iff (rst)
    position_load[0] |=> !position_load[0])
    else $error("restore load pulse too long");

  c_powerup_load: cover property (@(posedge core_clk)
    $fell(rst) ##1 position_load[0]);
  c_wrap_restore: cover property (@(posedge core_clk) disable iff (rst)
    calc0 && s_reg.homed[0] && encoder_reading[0] < s_reg.home_enc[0]);
  c_two_sided: cover property (@(posedge core_clk) disable iff (rst)
    calc0 && s_reg.homed[0] && two_sided_mode[0] ##1 position_valid[0]);
  c_master_load: cover property (@(posedge core_clk) disable iff (rst)
    position_load[1] && position_valid[1]);

endmodule // apr_restore

//--- test/apr_enc_model.sv
// ------------------------------------------------------------
// Multi-turn absolute encoder, one axis
// ------------------------------------------------------------
module apr_enc_model
(
  input  wire logic signed [31:0] turns,
  output logic             [11:0] reading
);
  timeunit 1ns;
  timeprecision 1ns;
  import apr_pkg::*;
  // Counter keeps the low bits only, so it wraps to zero at the full count
  assign reading = turns[APR_ENC_BITS-1:0];
endmodule // apr_enc_model

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import apr_pkg::*;
  typedef struct {logic a; logic t; logic [31:0] home_machine_position, home_encoder_reading, trav;} apr_row_t;
  logic               core_clk = 0, rst = 1, warm = 0, set = 0, clr = 0;
  logic               auto_on = 0, two = 0;
  logic               abs_m = 1, abs_s = 0;
  logic signed [31:0] turns = 100;
  logic [31:0]        mpos = '0;
  logic [1:0][11:0]   enc;
  logic [1:0][31:0]   rpos;
  logic [1:0]         load, valid, homed;
  int                 err_count = 0, checks = 0;
  logic [31:0]        exp_pos;
  // Travel forward inside one full count one-sided, or within half a full count either way two-sided
  apr_row_t rows [7] = '{
    '{1, 0, 32'h0, 32'd1375, 32'd1000}, '{1, 0, 32'h0, 32'd1375, 32'd3000},
    '{1, 0, 32'hffff_fc18, 32'd1375, 32'h0},
    '{1, 0, 32'h5, 32'd4000, 32'd4095}, '{1, 1, 32'h0, 32'd1375, 32'hffff_f830},
    '{1, 1, 32'h7, 32'd3000, 32'd1500}, '{0, 0, 32'h7, 32'd3000, 32'd1500}};
  always #25 core_clk = ~core_clk;
  apr_enc_model enc_m (.turns(turns), .reading(enc[0]));
  apr_enc_model enc_s (.turns(turns), .reading(enc[1]));
  apr_restore dut (.core_clk(core_clk), .rst(rst), .warm_start(warm),
    .axis_is_absolute({abs_s, abs_m}), .auto_calc_en({2{auto_on}}),
    .two_sided_mode({2{two}}), .set_home_command({2{set}}),
    .clear_home_command({2{clr}}), .encoder_reading(enc),
    .machine_position({2{mpos}}), .restored_position(rpos),
    .position_load(load), .position_valid(valid), .home_defined(homed));
  // ------------------------------------------------------------
  // Shared tasks; all entered and left at a falling edge
  // ------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task do_home();
    set = 1;
    @(negedge core_clk) set = 0;
  endtask
  task do_warm();
    warm = 1;
    @(negedge core_clk) warm = 0;
    @(negedge core_clk);
  endtask
  task tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(50 * 3000);
    err_count++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    check("pu_load", 32'(load), 32'h1);
    check("pu_pos", rpos[0], 32'd100);
    check("pu_homed", 32'(homed), 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      auto_on = rows[i].a;
      two = rows[i].t;
      turns = rows[i].home_encoder_reading;
      mpos = rows[i].home_machine_position;
      do_home();
      check("homed", 32'(homed), 32'h1);
      turns = rows[i].home_encoder_reading + rows[i].trav;
      mpos = 32'h1234;
      do_warm();
      exp_pos = rows[i].a ? rows[i].home_machine_position + rows[i].trav
                          : (rows[i].home_encoder_reading + rows[i].trav) & 32'h0000_0fff;
      check("pos", rpos[0], exp_pos);
      check("load", 32'(load), 32'h1);
      check("valid", 32'(valid[0]), 32'(rows[i].a));
      $display("test row %0d done", i);
    end
    clr = 1;
    auto_on = 1;
    turns = 77;
    @(negedge core_clk) clr = 0;
    do_warm();
    check("nohome_pos", rpos[0], 32'd77);
    check("nohome_vh", 32'({valid, homed}), 32'h0);
    $display("test unhomed done");
    // Warm held through the calc cycle gives a single restore
    warm = 1;
    repeat (2) @(negedge core_clk);
    warm = 0;
    check("held_load", 32'(load), 32'h1);
    @(negedge core_clk);
    check("held_once", 32'(load), 32'h0);
    $display("test held warm done");
    set = 1;
    clr = 1;
    @(negedge core_clk);
    set = 0;
    clr = 0;
    check("set_wins", 32'({valid, homed}), 32'h5);
    turns = 32'sh0000_005d;
    do_warm();
    check("rehome_pos", rpos[0], 32'h0000_1244);
    $display("test set over clear done");
    rst = 1;
    repeat (2) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    check("rst_load", 32'(load), 32'h1);
    check("rst_pos", rpos[0], 32'h0000_005d);
    check("rst_vh", 32'({valid, homed}), 32'h0);
    @(negedge core_clk);
    check("rst_load_end", 32'(load), 32'h0);
    $display("test mid reset done");
    abs_m = 0;
    abs_s = 1;
    do_home();
    check("swap_vh", 32'({valid, homed}), 32'ha);
    do_warm();
    check("swap_load", 32'(load), 32'h2);
    check("swap_pos", rpos[1], 32'h0000_1234);
    check("swap_valid", 32'(valid), 32'h2);
    $display("test lane swap done");
    tally_and_finish();
  end
endmodule // tb_top
